// ---- sink_training_config_mirror_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module sink_training_config_mirror_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        sel = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        rec_clk = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    wire         awr_o [2];
    wire         wr_o [2];
    wire         bv_o [2];
    wire         arr_o [2];
    wire         rv_o [2];
    wire  [1:0]  br_o [2];
    wire  [1:0]  rr_o [2];
    wire  [31:0] rd_o [2];
    wire         tco;
    wire  [29:0] pins;
    int          errors = 0;
    int          num_checks = 0;
    int          hi = 0;
    int          h0;
    logic [5:0]  lv [4] = '{6'h25, 6'h1A, 6'h3F, 6'h0B};
    stc_link_if lnk ();
    always #50 aclk = ~aclk;
    // slow against aclk so the three-cycle sync lag stays small
    always #400 rec_clk = ~rec_clk;
    always @(posedge aclk) if (tco === 1'b1) hi <= hi + 1;
    stc_tx_end u_stc_tx_end (.aclk(aclk), .aresetn(aresetn), .link(lnk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid & ~sel), .s_axi_awready(awr_o[0]),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid & ~sel),
        .s_axi_wready(wr_o[0]), .s_axi_bresp(br_o[0]), .s_axi_bvalid(bv_o[0]),
        .s_axi_bready(bready & ~sel), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid & ~sel),
        .s_axi_arready(arr_o[0]), .s_axi_rdata(rd_o[0]), .s_axi_rresp(rr_o[0]),
        .s_axi_rvalid(rv_o[0]), .s_axi_rready(rready & ~sel));
    stc_sink_mirror u_stc_sink_mirror (.aclk(aclk), .aresetn(aresetn), .link(lnk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid & sel), .s_axi_awready(awr_o[1]),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid & sel),
        .s_axi_wready(wr_o[1]), .s_axi_bresp(br_o[1]), .s_axi_bvalid(bv_o[1]),
        .s_axi_bready(bready & sel), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid & sel),
        .s_axi_arready(arr_o[1]), .s_axi_rdata(rd_o[1]), .s_axi_rresp(rr_o[1]),
        .s_axi_rvalid(rv_o[1]), .s_axi_rready(rready & sel), .rec_clk_pin(rec_clk),
        .test_clk_out(tco), .link_quality_pattern(pins[5:4]), .scrambler_off_flag(pins[1]),
        .error_count_kind_select(pins[3:2]), .lane0_drive_setting(pins[11:6]),
        .lane1_drive_setting(pins[17:12]), .lane2_drive_setting(pins[23:18]),
        .lane3_drive_setting(pins[29:24]), .spread_amount_bit(pins[0]));
    stc_link_properties u_stc_link_properties (.aclk(aclk), .aresetn(aresetn),
        .cfg_valid(lnk.cfg_valid), .cfg_addr(lnk.cfg_addr), .cfg_data(lnk.cfg_data),
        .cfg_ready(lnk.cfg_ready));
    task automatic conclude;
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk_data({30'h0, g}, {30'h0, e});
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            errors++;
            conclude;
        end
    endtask
    task automatic rst;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic axw(input logic s, input logic [11:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        sel <= s;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awr_o[s]) awvalid <= 1'b0;
            if (wr_o[s]) wvalid <= 1'b0;
            r = br_o[s];
        end while (!(bv_o[s] === 1'b1) && n < 50);
        bready <= 1'b0;
        guard(n);
    endtask
    task automatic axr(input logic s, input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        sel <= s;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arr_o[s]) arvalid <= 1'b0;
            d = rd_o[s];
            r = rr_o[s];
        end while (!(rv_o[s] === 1'b1) && n < 50);
        rready <= 1'b0;
        guard(n);
    endtask
    task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axr(s, a, d, r);
        chk_data(d, e);
        chk_resp(r, er);
    endtask
    // command the transmitter, wait out busy, then read the mirrored copy
    task automatic sv(input logic [11:0] a, input logic [7:0] b, input logic [1:0] er,
                      input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        axw(1'b0, `STC_OFS_TX_CMD, {8'h00, b, 4'h0, a}, r);
        chk_resp(r, er);
        do begin
            axr(1'b0, `STC_OFS_TX_STAT, d, r);
            n++;
        end while (d[0] !== 1'b0 && n < 50);
        guard(n);
        rd(1'b1, a, e, `STC_RESP_OKAY);
    endtask
    initial begin
        logic [1:0] r;
        rst;
        for (int i = 0; i < 9; i++) rd(1'b1, 12'h410 + 12'(i * 4), {31'h0, i == 2}, 2'h0);
        rd(1'b1, 12'h500, 32'h0000_0000, `STC_RESP_SLVERR);
        axw(1'b1, `STC_OFS_SCR, 32'h0000_0000, r);
        chk_resp(r, `STC_RESP_OKAY);
        rd(1'b1, `STC_OFS_SCR, 32'h0000_0001, `STC_RESP_OKAY);
        // upper byte bits set on purpose: only the field may come back
        for (int c = 0; c < 4; c++) sv(`STC_OFS_LQP, {6'h3F, 2'(c)}, 2'h0, 32'(c));
        for (int c = 0; c < 3; c++) sv(`STC_OFS_ECS, {6'h3F, 2'(c)}, 2'h0, 32'(c));
        sv(`STC_OFS_ECS, 8'h03, `STC_RESP_SLVERR, 32'h0000_0002);
        rd(1'b0, `STC_OFS_TX_STAT, 32'h0000_0002, `STC_RESP_OKAY);
        for (int i = 0; i < 4; i++) sv(12'h420 + 12'(i * 4), {2'h3, lv[i]}, 2'h0, 32'(lv[i]));
        for (int i = 0; i < 4; i++) rd(1'b1, 12'h420 + 12'(i * 4), 32'(lv[i]), 2'h0);
        sv(`STC_OFS_SCR, 8'hFE, 2'h0, 32'h0000_0000);
        sv(`STC_OFS_SCR, 8'h01, 2'h0, 32'h0000_0001);
        sv(`STC_OFS_SPREAD, 8'h01, 2'h0, 32'h0000_0001);
        sv(`STC_OFS_SPREAD, 8'hFE, 2'h0, 32'h0000_0000);
        sv(`STC_OFS_RCE, 8'h00, 2'h0, 32'h0000_0000);
        chk_data({2'h0, pins}, {2'h0, lv[3], lv[2], lv[1], lv[0], 2'h3, 2'h2, 2'h2});
        h0 = hi;
        repeat (40) @(posedge aclk);
        chk_data(32'(hi - h0), 32'h0000_0000);
        sv(`STC_OFS_RCE, 8'h01, 2'h0, 32'h0000_0001);
        h0 = hi;
        repeat (40) @(posedge aclk);
        chk_data({31'h0, (hi - h0) >= 18 && (hi - h0) <= 22}, 32'h0000_0001);
        rst;
        rd(1'b1, `STC_OFS_SCR, 32'h0000_0001, `STC_RESP_OKAY);
        rd(1'b1, `STC_OFS_LANE2, 32'h0000_0000, `STC_RESP_OKAY);
        chk_data({2'h0, pins}, 32'h0000_0002);
        conclude;
    end
endmodule // sink_training_config_mirror_tb_top
`default_nettype wire

// ---- stc_axil_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_axil_port (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [`STC_AW-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [`STC_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [`STC_AW-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [`STC_DW-1:0]       s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic                     wr_en,
    output logic [`STC_AW-1:0]       wr_addr,
    output logic [`STC_DW-1:0]       wr_data,
    output logic [3:0]               wr_strb,
    input  wire logic                wr_err,
    output logic                     rd_en,
    output logic [`STC_AW-1:0]       rd_addr,
    input  wire logic [`STC_DW-1:0]  rd_data,
    input  wire logic                rd_err
);
    logic               aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic               awready_q, awready_d, wready_q, wready_d;
    logic               wr_en_q, wr_en_d, bvalid_q, bvalid_d;
    logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
    logic [`STC_AW-1:0] aw_addr_q, aw_addr_d;
    logic [`STC_DW-1:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0]         w_strb_q, w_strb_d;
    logic               arready_q, arready_d, rvalid_q, rvalid_d;
    logic               aw_hs, w_hs, ar_hs, done;

    assign aw_hs   = s_axi_awvalid & awready_q;
    assign w_hs    = s_axi_wvalid & wready_q;
    assign ar_hs   = s_axi_arvalid & arready_q;
    assign rd_en   = ar_hs;
    assign rd_addr = s_axi_araddr;

    // address and data may arrive in either order; the store waits for both
    always_comb begin
        done      = (aw_got_q | aw_hs) & (w_got_q | w_hs);
        aw_got_d  = (aw_got_q | aw_hs) & ~done;
        w_got_d   = (w_got_q | w_hs) & ~done;
        aw_addr_d = aw_hs ? s_axi_awaddr : aw_addr_q;
        w_data_d  = w_hs ? s_axi_wdata : w_data_q;
        w_strb_d  = w_hs ? s_axi_wstrb : w_strb_q;
        wr_en_d   = done;
        // response one cycle after the store so the error flag is settled
        bvalid_d  = wr_en_q | (bvalid_q & ~s_axi_bready);
        bresp_d   = wr_en_q ? (wr_err ? `STC_RESP_SLVERR : `STC_RESP_OKAY) : bresp_q;
        awready_d = ~aw_got_d & ~wr_en_d & ~bvalid_d;
        wready_d  = ~w_got_d & ~wr_en_d & ~bvalid_d;
        rvalid_d  = ar_hs | (rvalid_q & ~s_axi_rready);
        rdata_d   = ar_hs ? rd_data : rdata_q;
        rresp_d   = ar_hs ? (rd_err ? `STC_RESP_SLVERR : `STC_RESP_OKAY) : rresp_q;
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= 4'h0;
            wr_en_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `STC_RESP_OKAY;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `STC_RESP_OKAY;
            arready_q <= 1'b1;
        end else begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            aw_addr_q <= aw_addr_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            wr_en_q   <= wr_en_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            arready_q <= arready_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_en         = wr_en_q;
    assign wr_addr       = aw_addr_q;
    assign wr_data       = w_data_q;
    assign wr_strb       = w_strb_q;
endmodule // stc_axil_port
`default_nettype wire

// ---- stc_defs.svh ----
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

`define STC_AW          12
`define STC_DW          32
`define STC_LINK_DW     8

`define STC_OFS_LQP     12'h410
`define STC_OFS_RCE     12'h414
`define STC_OFS_SCR     12'h418
`define STC_OFS_ECS     12'h41C
`define STC_OFS_LANE0   12'h420
`define STC_OFS_LANE1   12'h424
`define STC_OFS_LANE2   12'h428
`define STC_OFS_LANE3   12'h42C
`define STC_OFS_SPREAD  12'h430

`define STC_OFS_TX_CMD  12'h000
`define STC_OFS_TX_STAT 12'h004
`define STC_CMD_OFS_LSB 0
`define STC_CMD_DAT_LSB 16

`define STC_LANE_MAXPE  5
`define STC_LANE_PE_LSB 3
`define STC_LANE_MAXSW  2
`define STC_LANE_SW_LSB 0

`define STC_LQP_NONE    2'h0
`define STC_LQP_D102    2'h1
`define STC_LQP_SER     2'h2
`define STC_LQP_PRBS7   2'h3
`define STC_ECS_BOTH    2'h0
`define STC_ECS_DISP    2'h1
`define STC_ECS_ILLEGAL 2'h2
`define STC_ECS_RSVD    2'h3

`define STC_CODE_RST    2'h0
`define STC_BIT_RST     1'b0
`define STC_SCR_RST     1'b1
`define STC_LANE_RST    6'h00

`define STC_RESP_OKAY   2'h0
`define STC_RESP_SLVERR 2'h2

`endif

// ---- stc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
interface stc_link_if;
    logic                      cfg_valid;
    logic [`STC_AW-1:0]        cfg_addr;
    logic [`STC_LINK_DW-1:0]   cfg_data;
    logic                      cfg_ready;
    modport sink   (input cfg_valid, input cfg_addr, input cfg_data, output cfg_ready);
    modport source (output cfg_valid, output cfg_addr, output cfg_data, input cfg_ready);
endinterface
`default_nettype wire

// ---- stc_link_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_link_properties (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    cfg_valid,
    input wire logic [`STC_AW-1:0]      cfg_addr,
    input wire logic [`STC_LINK_DW-1:0] cfg_data,
    input wire logic                    cfg_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both ends come out of reset quiet
    reset_idle_a: assert property ($rose(aresetn) |-> !cfg_valid && !cfg_ready)
        else $error("link not idle after reset");
    ready_up_a: assert property (aresetn && $past(aresetn) |-> cfg_ready)
        else $error("sink not ready after reset");
    ready_wait_a: assert property (cfg_valid |-> cfg_ready)
        else $error("beat offered while sink not ready");
    valid_drop_a: assert property (cfg_valid && cfg_ready |=> !cfg_valid)
        else $error("second beat after one command");
    hold_beat_a: assert property (cfg_valid && !cfg_ready |=>
        cfg_valid && $stable(cfg_addr) && $stable(cfg_data))
        else $error("beat changed before taken");
    fall_taken_a: assert property ($fell(cfg_valid) |-> $past(cfg_ready))
        else $error("beat withdrawn untaken");
    addr_map_a: assert property (cfg_valid |-> cfg_addr inside {[12'h410:12'h430]}
        && cfg_addr[1:0] == 2'h0)
        else $error("beat to unmapped field");
    ecs_code_a: assert property (cfg_valid && cfg_addr == `STC_OFS_ECS |->
        cfg_data[1:0] != `STC_ECS_RSVD)
        else $error("reserved error select sent");
endmodule // stc_link_properties
`default_nettype wire

// ---- stc_pkg.sv ----
package stc_pkg;
    typedef logic [1:0] stc_code_t;
    typedef logic [5:0] stc_lane_t;
    typedef enum logic {
        stc_tx_idle,
        stc_tx_send
    } stc_tx_state_t;
endpackage

// ---- stc_sink_mirror.sv ----
// Contract
// - pattern field readable at 0x410, read-only
// - pattern codes none, D10.2, SER, PRBS7
// - enable bit drives recovered clock out
// - scrambler-off bit reads transmitter state
// - scrambler-off resets to disabled value
// - error select codes both, disp, illegal
// - transmitter writes each lane's training set
// - lane bit 5 shows max pre-emphasis
// - lane bits 4:3 pre-emphasis level
// - lane bit 2 shows max swing
// - lane bits 1:0 swing level
// - lanes 1-3 share lane 0 layout
// - downspread bit one means 0.5 percent
// - transmitter sets downspread bit when enabled
// - fields arrive as link writes, mirrored here
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_sink_mirror (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    stc_link_if.sink                 link,
    input  wire logic [`STC_AW-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [`STC_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [`STC_AW-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [`STC_DW-1:0]       s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                rec_clk_pin,
    output logic                     test_clk_out,
    output stc_pkg::stc_code_t       link_quality_pattern,
    output logic                     scrambler_off_flag,
    output stc_pkg::stc_code_t       error_count_kind_select,
    output stc_pkg::stc_lane_t       lane0_drive_setting,
    output stc_pkg::stc_lane_t       lane1_drive_setting,
    output stc_pkg::stc_lane_t       lane2_drive_setting,
    output stc_pkg::stc_lane_t       lane3_drive_setting,
    output logic                     spread_amount_bit
);
    stc_pkg::stc_code_t lqp_q, lqp_d;
    stc_pkg::stc_code_t ecs_q, ecs_d;
    stc_pkg::stc_lane_t lane_q [4];
    stc_pkg::stc_lane_t lane_d [4];
    logic               rce_q, rce_d;
    logic               scr_q, scr_d;
    logic               spread_q, spread_d;
    logic               ready_q, ready_d;
    logic               rec_meta_q, rec_sync_q, test_clk_q, test_clk_d;
    logic               take;
    logic [`STC_DW:0]   rd_word;
    logic [`STC_AW-1:0] rd_addr;
    logic [`STC_DW-1:0] rd_data;
    logic               rd_err;

    // lane index for an offset in the lane window, or 4 when outside it
    function automatic logic [2:0] lane_of(input logic [`STC_AW-1:0] a);
        logic [2:0] idx;
        idx = 3'd4;
        case (a)
            `STC_OFS_LANE0: idx = 3'd0;
            `STC_OFS_LANE1: idx = 3'd1;
            `STC_OFS_LANE2: idx = 3'd2;
            `STC_OFS_LANE3: idx = 3'd3;
            default:        idx = 3'd4;
        endcase
        return idx;
    endfunction

    // host view of the mirror; upper bits pad with zero
    function automatic logic [`STC_DW:0] mirror_word(input logic [`STC_AW-1:0] a);
        logic [`STC_DW:0] w;
        logic [2:0]       l;
        w = '0;
        l = lane_of(a);
        case (a)
            `STC_OFS_LQP:    w[1:0] = lqp_q;
            `STC_OFS_RCE:    w[0]   = rce_q;
            `STC_OFS_SCR:    w[0]   = scr_q;
            `STC_OFS_ECS:    w[1:0] = ecs_q;
            `STC_OFS_SPREAD: w[0]   = spread_q;
            default: begin
                if (l < 3'd4) begin
                    w[5:0] = lane_q[l[1:0]];
                end else begin
                    w[`STC_DW] = 1'b1;
                end
            end
        endcase
        return w;
    endfunction

    // the link is ready one cycle after reset ends; every beat lands in one cycle
    assign take = link.cfg_valid & ready_q;

    always_comb begin
        logic [2:0] l;
        l        = lane_of(link.cfg_addr);
        lqp_d    = lqp_q;
        rce_d    = rce_q;
        scr_d    = scr_q;
        ecs_d    = ecs_q;
        spread_d = spread_q;
        ready_d  = 1'b1;
        for (int i = 0; i < 4; i++) begin
            lane_d[i] = lane_q[i];
        end
        if (take) begin
            case (link.cfg_addr)
                `STC_OFS_LQP:    lqp_d    = link.cfg_data[1:0];
                `STC_OFS_RCE:    rce_d    = link.cfg_data[0];
                `STC_OFS_SCR:    scr_d    = link.cfg_data[0];
                `STC_OFS_ECS:    ecs_d    = link.cfg_data[1:0];
                `STC_OFS_SPREAD: spread_d = link.cfg_data[0];
                default: begin
                    if (l < 3'd4) begin
                        lane_d[l[1:0]] = link.cfg_data[5:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lqp_q    <= `STC_CODE_RST;
            rce_q    <= `STC_BIT_RST;
            scr_q    <= `STC_SCR_RST;
            ecs_q    <= `STC_CODE_RST;
            spread_q <= `STC_BIT_RST;
            ready_q  <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                lane_q[i] <= `STC_LANE_RST;
            end
        end else begin
            lqp_q    <= lqp_d;
            rce_q    <= rce_d;
            scr_q    <= scr_d;
            ecs_q    <= ecs_d;
            spread_q <= spread_d;
            ready_q  <= ready_d;
            for (int i = 0; i < 4; i++) begin
                lane_q[i] <= lane_d[i];
            end
        end
    end

    // recovered clock is a foreign pin: two flops, then gated by the enable.
    // limitation: the copy on the test port is resampled at aclk rate
    assign test_clk_d = rce_q & rec_sync_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rec_meta_q <= 1'b0;
            rec_sync_q <= 1'b0;
            test_clk_q <= 1'b0;
        end else begin
            rec_meta_q <= rec_clk_pin;
            rec_sync_q <= rec_meta_q;
            test_clk_q <= test_clk_d;
        end
    end

    // a process, not an assign: the function also reads the stored fields
    always_comb begin
        rd_word = mirror_word(rd_addr);
    end
    assign rd_data = rd_word[`STC_DW-1:0];
    assign rd_err  = rd_word[`STC_DW];

    // every host write answers okay and touches nothing
    stc_axil_port u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (),
        .wr_addr       (),
        .wr_data       (),
        .wr_strb       (),
        .wr_err        (1'b0),
        .rd_en         (),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    assign link.cfg_ready           = ready_q;
    assign test_clk_out             = test_clk_q;
    assign link_quality_pattern     = lqp_q;
    assign scrambler_off_flag       = scr_q;
    assign error_count_kind_select  = ecs_q;
    assign lane0_drive_setting      = lane_q[0];
    assign lane1_drive_setting      = lane_q[1];
    assign lane2_drive_setting      = lane_q[2];
    assign lane3_drive_setting      = lane_q[3];
    assign spread_amount_bit        = spread_q;
endmodule // stc_sink_mirror
`default_nettype wire

// ---- stc_tx_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stc_defs.svh"
module stc_tx_end (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    stc_link_if.source               link,
    input  wire logic [`STC_AW-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [`STC_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [`STC_AW-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [`STC_DW-1:0]       s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    stc_pkg::stc_tx_state_t  st_q, st_d;
    logic [`STC_AW-1:0]      addr_q, addr_d;
    logic [`STC_LINK_DW-1:0] data_q, data_d;
    logic                    refused_q, refused_d;
    logic                    wr_en, wr_err, is_cmd;
    logic [`STC_AW-1:0]      wr_addr;
    logic [`STC_DW-1:0]      wr_data;
    logic [`STC_AW-1:0]      rd_addr;
    logic [`STC_DW-1:0]      rd_data;
    logic [`STC_AW-1:0]      tgt;
    logic [`STC_LINK_DW-1:0] val;

    assign tgt    = wr_data[`STC_CMD_OFS_LSB +: `STC_AW];
    assign val    = wr_data[`STC_CMD_DAT_LSB +: `STC_LINK_DW];
    assign is_cmd = wr_addr == `STC_OFS_TX_CMD;
    // a write off the command offset, busy, or the reserved error-select code, refuses the order
    assign wr_err = ~is_cmd | (st_q != stc_pkg::stc_tx_idle)
                  | (tgt == `STC_OFS_ECS && val[1:0] == `STC_ECS_RSVD);

    always_comb begin
        st_d      = st_q;
        addr_d    = addr_q;
        data_d    = data_q;
        refused_d = refused_q;
        if (wr_en) begin
            refused_d = wr_err;
        end
        case (st_q)
            stc_pkg::stc_tx_idle: begin
                if (wr_en && !wr_err) begin
                    st_d   = stc_pkg::stc_tx_send;
                    addr_d = tgt;
                    data_d = val;
                end
            end
            stc_pkg::stc_tx_send: begin
                if (link.cfg_ready) begin
                    st_d = stc_pkg::stc_tx_idle;
                end
            end
            default: st_d = stc_pkg::stc_tx_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q      <= stc_pkg::stc_tx_idle;
            addr_q    <= '0;
            data_q    <= '0;
            refused_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            addr_q    <= addr_d;
            data_q    <= data_d;
            refused_q <= refused_d;
        end
    end

    assign rd_data = (rd_addr == `STC_OFS_TX_STAT)
                   ? {30'h0000_0000, refused_q, st_q == stc_pkg::stc_tx_send} : '0;

    stc_axil_port u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (),
        .wr_err        (wr_err),
        .rd_en         (),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_addr != `STC_OFS_TX_STAT && rd_addr != `STC_OFS_TX_CMD)
    );

    assign link.cfg_valid = st_q == stc_pkg::stc_tx_send;
    assign link.cfg_addr  = addr_q;
    assign link.cfg_data  = data_q;
endmodule // stc_tx_end
`default_nettype wire
